// [rtcc_pkg.sv]
// package for the real-time counter core: register map, fields, constants
// assumes a single core_clk domain; prescaler source is core_clk itself
package rtcc_pkg;
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_EVENT_OUTPUT_CTRL = 5'h01;
    localparam logic [4:0] ADDR_IEN_CLR = 5'h02;
    localparam logic [4:0] ADDR_IEN_SET = 5'h03;
    localparam logic [4:0] ADDR_FLAGS = 5'h04;
    localparam logic [4:0] ADDR_STATUS = 5'h05;
    localparam logic [4:0] ADDR_DBG = 5'h06;
    localparam logic [4:0] ADDR_COUNT = 5'h07;
    localparam logic [4:0] ADDR_TOP = 5'h08;
    localparam logic [4:0] ADDR_COMPARE0_FLAG = 5'h09;
    localparam logic [4:0] ADDR_CMP1 = 5'h0a;
    localparam logic [4:0] ADDR_ALARM_VALUE_0 = 5'h0b;
    localparam logic [4:0] ADDR_AMASK0 = 5'h0c;

    // ctrl fields
    localparam int CTRL_SOFT_RESET = 0;
    localparam int CTRL_ENABLE = 1;
    localparam int CTRL_MODE_LO = 2;
    localparam int CTRL_HOUR_FMT = 6;
    localparam int CTRL_CLR_MATCH = 7;
    localparam int CTRL_PRESC_LO = 8;

    // flag / enable bit positions
    localparam int FLG_COMPARE0_FLAG = 0;
    localparam int FLG_CMP1 = 1;
    localparam int FLG_SYNC = 6;
    localparam int FLG_WRAP = 7;

    // event control positions
    localparam int EV_PER_LO = 0;
    localparam int EV_COMPARE0_FLAG = 8;
    localparam int EV_CMP1 = 9;
    localparam int EV_WRAP = 15;

    localparam logic [1:0] MODE_COUNT32 = 2'h0;
    localparam logic [1:0] MODE_COUNT16 = 2'h1;
    localparam logic [1:0] MODE_CALENDAR = 2'h2;

    // calendar field layout
    localparam int CAL_SEC_LO = 0;
    localparam int CAL_MIN_LO = 6;
    localparam int CAL_HOUR_LO = 12;
    localparam int CAL_DAY_LO = 17;
    localparam int CAL_MON_LO = 22;
    localparam int CAL_YEAR_LO = 26;
    localparam logic [5:0] YEAR_TOP = 6'h3f;
    localparam logic [2:0] MASK_RESET = 3'h0;

    localparam logic [15:0] TOP_RESET = 16'hffff;
    localparam logic [31:0] CAL_RESET = 32'h00420000;

    typedef struct packed {
        logic [4:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rtcc_bus_req_type;

    typedef struct packed {
        logic [7:0] periodic;
        logic compare0_flag;
        logic cmp1;
        logic wrap;
    } rtcc_event_type;
endpackage

// [rtcc_core.sv]
// real-time counter core: 32-bit counter, 16-bit counter and calendar
// assumes a synchronous register port; prescaler runs from core_clk
module rtcc_core #(
    parameter int PRESC_W = 10,
    parameter int SYNC_CYCLES = 2
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    output logic [7:0] periodic_tick_event,
    output logic ev_compare0_flag,
    output logic ev_cmp1,
    output logic ev_wrap
);
    rtcc_pkg::rtcc_bus_req_type req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic enable_q, hour_format_bit_q, clear_on_match_bit_q, dbg_run_q;
    logic [1:0] mode_q;
    logic [3:0] presc_sel_q;
    logic [15:0] event_output_ctrl_q;
    logic [7:0] irq_en_q, irq_flag_reg_q;
    logic [31:0] count_q, compare_value_0_q, alarm_value_0_q;
    logic [15:0] top_q, compare_value_1_q;
    logic [2:0] alarm_field_select_q;
    logic [PRESC_W-1:0] presc_q;
    logic [7:0] sync_cnt_q;
    logic compare0_flag_hit_q, cmp1_hit_q;
    logic soft_rst;
    logic wr_hit_ctrl;

    assign wr_hit_ctrl = req.wr && req.addr == rtcc_pkg::ADDR_CTRL;
    // soft reset acts only through a ctrl write with the bit set
    assign soft_rst = wr_hit_ctrl && req.wdata[rtcc_pkg::CTRL_SOFT_RESET];

    // calendar helpers
    function automatic logic [4:0] days_in(input logic [3:0] m,
                                            input logic [5:0] y);
        case (m)
            4'h2: days_in = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            4'h4, 4'h6, 4'h9, 4'hb: days_in = 5'h1e;
            default: days_in = 5'h1f;
        endcase
    endfunction

    function automatic logic [31:0] cal_step(input logic [31:0] c,
                                             input logic fmt12);
        logic [5:0] s, mi, y;
        logic [4:0] h, d;
        logic [3:0] mo;
        logic [4:0] hmax;
        s = c[rtcc_pkg::CAL_MIN_LO-1:rtcc_pkg::CAL_SEC_LO];
        mi = c[rtcc_pkg::CAL_HOUR_LO-1:rtcc_pkg::CAL_MIN_LO];
        h = c[rtcc_pkg::CAL_DAY_LO-1:rtcc_pkg::CAL_HOUR_LO];
        d = c[rtcc_pkg::CAL_MON_LO-1:rtcc_pkg::CAL_DAY_LO];
        mo = c[rtcc_pkg::CAL_YEAR_LO-1:rtcc_pkg::CAL_MON_LO];
        y = c[31:rtcc_pkg::CAL_YEAR_LO];
        // 12-hour: bit4 is pm, low bits 1..12; 24-hour: 0..23
        hmax = fmt12 ? 5'h0c : 5'h17;
        if (s != 6'h3b) begin
            s = s + 6'h1;
        end else begin
            s = 6'h0;
            if (mi != 6'h3b) begin
                mi = mi + 6'h1;
            end else begin
                mi = 6'h0;
                if (fmt12) begin
                    if (h[3:0] == 4'hb) begin
                        h = {~h[4], 4'hc};
                    end else if (h[3:0] == hmax[3:0]) begin
                        h = {h[4], 4'h1};
                    end else begin
                        h = h + 5'h1;
                    end
                end else if (h != hmax) begin
                    h = h + 5'h1;
                end
                if (fmt12 ? (h == 5'h0c) : (h == hmax + 5'h0
                        && mi == 6'h0 && c[16:12] == hmax)) begin
                    h = fmt12 ? h : 5'h0;
                end
                if (fmt12 ? (h == 5'h0c && c[16] == 1'b1)
                        : (c[16:12] == hmax)) begin
                    if (!fmt12) begin
                        h = 5'h0;
                    end
                    if (d != days_in(mo, y)) begin
                        d = d + 5'h1;
                    end else begin
                        d = 5'h1;
                        if (mo != 4'hc) begin
                            mo = mo + 4'h1;
                        end else begin
                            mo = 4'h1;
                            y = y + 6'h1; // wraps 63 to 0
                        end
                    end
                end
            end
        end
        cal_step = {y, mo, d, h, mi, s};
    endfunction

    // select n (1..6) compares the lowest n fields, from seconds upward (0 = never matches, 7 = always matches)
    function automatic logic alarm_hit(input logic [31:0] c,
                                       input logic [31:0] a,
                                       input logic [2:0] sel);
        logic [31:0] m;
        m = 32'h0;
        case (sel)
            3'h1: m = 32'h0000003f;
            3'h2: m = 32'h00000fff;
            3'h3: m = 32'h0001ffff;
            3'h4: m = 32'h003fffff;
            3'h5: m = 32'h03ffffff;
            3'h6: m = 32'hffffffff;
            default: m = 32'h0;
        endcase
        alarm_hit = (sel != 3'h0) && ((c & m) == (a & m));
    endfunction

    // prescaler and tick
    logic [PRESC_W-1:0] presc_next;
    logic tick;
    logic [PRESC_W:0] rise;
    assign presc_next = presc_q + PRESC_W'(1);
    assign rise = {1'b0, presc_next & ~presc_q};
    assign tick = enable_q && (presc_sel_q == 4'h0 ? 1'b1
                  : rise[presc_sel_q - 4'h1]);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            presc_q <= '0;
        end else if (soft_rst || !enable_q) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_next;
        end
    end

    // match conditions
    logic wrap32, wrap16, wrapcal, m0, m1, wrap_now;
    logic [31:0] cal_next;
    assign cal_next = cal_step(count_q, hour_format_bit_q);
    assign wrap32 = count_q == 32'hffffffff;
    assign wrap16 = count_q[15:0] == top_q;
    assign wrapcal = cal_next[31:rtcc_pkg::CAL_YEAR_LO] == 6'h0
                     && count_q[31:rtcc_pkg::CAL_YEAR_LO] == rtcc_pkg::YEAR_TOP;
    assign m0 = mode_q == rtcc_pkg::MODE_CALENDAR
                ? alarm_hit(count_q, alarm_value_0_q, alarm_field_select_q)
                : mode_q == rtcc_pkg::MODE_COUNT16
                ? count_q[15:0] == compare_value_0_q[15:0]
                : count_q == compare_value_0_q;
    assign m1 = mode_q == rtcc_pkg::MODE_COUNT16
                && count_q[15:0] == compare_value_1_q;

    // events raised on a tick, one cycle pulses
    logic ev_c0, ev_c1, ev_w;
    assign ev_c0 = tick && compare0_flag_hit_q;
    assign ev_c1 = tick && cmp1_hit_q;
    assign wrap_now = clear_on_match_bit_q && mode_q != rtcc_pkg::MODE_COUNT16
                      ? compare0_flag_hit_q
                      : mode_q == rtcc_pkg::MODE_COUNT32 ? wrap32
                      : mode_q == rtcc_pkg::MODE_COUNT16 ? wrap16 : wrapcal;
    assign ev_w = tick && wrap_now;

    // latch the match on a tick, flag on the following tick
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            compare0_flag_hit_q <= 1'b0;
            cmp1_hit_q <= 1'b0;
        end else if (soft_rst || !enable_q) begin
            compare0_flag_hit_q <= 1'b0;
            cmp1_hit_q <= 1'b0;
        end else if (tick) begin
            compare0_flag_hit_q <= m0;
            cmp1_hit_q <= m1;
        end
    end

    // counter
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= '0;
        end else if (soft_rst) begin
            count_q <= '0;
        end else if (req.wr && req.addr == rtcc_pkg::ADDR_COUNT) begin
            count_q <= req.wdata;
        end else if (tick) begin
            if (clear_on_match_bit_q && compare0_flag_hit_q
                    && mode_q != rtcc_pkg::MODE_COUNT16) begin
                count_q <= mode_q == rtcc_pkg::MODE_CALENDAR
                           ? rtcc_pkg::CAL_RESET : '0;
            end else if (mode_q == rtcc_pkg::MODE_COUNT16) begin
                count_q <= wrap16 ? '0
                           : {16'h0, count_q[15:0] + 16'h1};
            end else if (mode_q == rtcc_pkg::MODE_CALENDAR) begin
                count_q <= cal_next;
            end else begin
                count_q <= count_q + 32'h1;
            end
        end
    end

    // control register; protected fields only while disabled
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            enable_q <= 1'b0;
            mode_q <= rtcc_pkg::MODE_COUNT32;
            presc_sel_q <= 4'h0;
            hour_format_bit_q <= 1'b0;
            clear_on_match_bit_q <= 1'b0;
            event_output_ctrl_q <= 16'h0;
        end else if (soft_rst) begin
            enable_q <= 1'b0;
            mode_q <= rtcc_pkg::MODE_COUNT32;
            presc_sel_q <= 4'h0;
            hour_format_bit_q <= 1'b0;
            clear_on_match_bit_q <= 1'b0;
            event_output_ctrl_q <= 16'h0;
        end else begin
            if (wr_hit_ctrl) begin
                enable_q <= req.wdata[rtcc_pkg::CTRL_ENABLE];
                if (!enable_q) begin
                    mode_q <= req.wdata[rtcc_pkg::CTRL_MODE_LO +: 2];
                    presc_sel_q <= req.wdata[rtcc_pkg::CTRL_PRESC_LO +: 4];
                    hour_format_bit_q <= req.wdata[rtcc_pkg::CTRL_HOUR_FMT];
                    clear_on_match_bit_q <=
                        req.wdata[rtcc_pkg::CTRL_CLR_MATCH];
                end
            end
            if (req.wr && req.addr == rtcc_pkg::ADDR_EVENT_OUTPUT_CTRL && !enable_q) begin
                event_output_ctrl_q <= req.wdata[15:0];
            end
        end
    end

    // compare/alarm/top values and debug control (debug survives soft reset)
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            top_q <= rtcc_pkg::TOP_RESET;
            compare_value_0_q <= '0;
            compare_value_1_q <= '0;
            alarm_value_0_q <= '0;
            alarm_field_select_q <= rtcc_pkg::MASK_RESET;
        end else if (soft_rst) begin
            top_q <= rtcc_pkg::TOP_RESET;
            compare_value_0_q <= '0;
            compare_value_1_q <= '0;
            alarm_value_0_q <= '0;
            alarm_field_select_q <= rtcc_pkg::MASK_RESET;
        end else if (req.wr) begin
            case (req.addr)
                rtcc_pkg::ADDR_TOP: top_q <= req.wdata[15:0];
                rtcc_pkg::ADDR_COMPARE0_FLAG: compare_value_0_q <= req.wdata;
                rtcc_pkg::ADDR_CMP1: compare_value_1_q <= req.wdata[15:0];
                rtcc_pkg::ADDR_ALARM_VALUE_0: alarm_value_0_q <= req.wdata;
                rtcc_pkg::ADDR_AMASK0:
                    alarm_field_select_q <= req.wdata[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dbg_run_q <= 1'b0;
        end else if (req.wr && req.addr == rtcc_pkg::ADDR_DBG) begin
            dbg_run_q <= req.wdata[0];
        end
    end

    // synchronised-write busy counter
    logic sync_wr;
    assign sync_wr = req.wr && (req.addr == rtcc_pkg::ADDR_CTRL
                     || (req.addr >= rtcc_pkg::ADDR_COUNT
                     && req.addr <= rtcc_pkg::ADDR_AMASK0));
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync_cnt_q <= 8'h0;
        end else if (sync_wr) begin
            sync_cnt_q <= 8'(SYNC_CYCLES);
        end else if (sync_cnt_q != 8'h0) begin
            sync_cnt_q <= sync_cnt_q - 8'h1;
        end
    end
    logic sync_done;
    assign sync_done = sync_cnt_q == 8'h1;

    // interrupt enables
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_en_q <= 8'h0;
        end else if (soft_rst) begin
            irq_en_q <= 8'h0;
        end else if (req.wr && req.addr == rtcc_pkg::ADDR_IEN_SET) begin
            irq_en_q <= irq_en_q | req.wdata[7:0];
        end else if (req.wr && req.addr == rtcc_pkg::ADDR_IEN_CLR) begin
            irq_en_q <= irq_en_q & ~req.wdata[7:0];
        end
    end

    // flags: write one clears, set wins
    logic [7:0] set_v, clr_v;
    always_comb begin
        set_v = 8'h0;
        set_v[rtcc_pkg::FLG_COMPARE0_FLAG] = ev_c0;
        set_v[rtcc_pkg::FLG_CMP1] = ev_c1;
        set_v[rtcc_pkg::FLG_SYNC] = sync_done;
        set_v[rtcc_pkg::FLG_WRAP] = ev_w;
        clr_v = (req.wr && req.addr == rtcc_pkg::ADDR_FLAGS)
                ? req.wdata[7:0] : 8'h0;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_flag_reg_q <= 8'h0;
        end else if (soft_rst) begin
            irq_flag_reg_q <= 8'h0;
        end else begin
            irq_flag_reg_q <= (irq_flag_reg_q & ~clr_v) | set_v;
        end
    end

    // single irq line, registered; runs on core_clk so it wakes
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_flag_reg_q & ~clr_v) | set_v)
                   & irq_en_q & ~(soft_rst ? 8'hff : 8'h0));
        end
    end

    // event outputs
    rtcc_pkg::rtcc_event_type ev_d;
    always_comb begin
        ev_d.periodic = (presc_sel_q == 4'h0 || !enable_q) ? 8'h0
                        : rise[9:2] & event_output_ctrl_q[7:0];
        ev_d.compare0_flag = ev_c0 && event_output_ctrl_q[rtcc_pkg::EV_COMPARE0_FLAG];
        ev_d.cmp1 = ev_c1 && event_output_ctrl_q[rtcc_pkg::EV_CMP1];
        ev_d.wrap = ev_w && event_output_ctrl_q[rtcc_pkg::EV_WRAP];
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            periodic_tick_event <= 8'h0;
            ev_compare0_flag <= 1'b0;
            ev_cmp1 <= 1'b0;
            ev_wrap <= 1'b0;
        end else begin
            periodic_tick_event <= ev_d.periodic;
            ev_compare0_flag <= ev_d.compare0_flag;
            ev_cmp1 <= ev_d.cmp1;
            ev_wrap <= ev_d.wrap;
        end
    end

    // read data, one cycle after the strobe
    logic [31:0] rd_v;
    always_comb begin
        case (req.addr)
            rtcc_pkg::ADDR_CTRL: rd_v = {20'h0, presc_sel_q,
                clear_on_match_bit_q, hour_format_bit_q, 2'h0, mode_q,
                enable_q, 1'b0};
            rtcc_pkg::ADDR_EVENT_OUTPUT_CTRL: rd_v = {16'h0, event_output_ctrl_q};
            rtcc_pkg::ADDR_IEN_CLR, rtcc_pkg::ADDR_IEN_SET:
                rd_v = {24'h0, irq_en_q};
            rtcc_pkg::ADDR_FLAGS: rd_v = {24'h0, irq_flag_reg_q};
            rtcc_pkg::ADDR_STATUS: rd_v = {24'h0, sync_cnt_q != 8'h0, 7'h0};
            rtcc_pkg::ADDR_DBG: rd_v = {31'h0, dbg_run_q};
            rtcc_pkg::ADDR_COUNT: rd_v = count_q;
            rtcc_pkg::ADDR_TOP: rd_v = {16'h0, top_q};
            rtcc_pkg::ADDR_COMPARE0_FLAG: rd_v = compare_value_0_q;
            rtcc_pkg::ADDR_CMP1: rd_v = {16'h0, compare_value_1_q};
            rtcc_pkg::ADDR_ALARM_VALUE_0: rd_v = alarm_value_0_q;
            rtcc_pkg::ADDR_AMASK0: rd_v = {29'h0, alarm_field_select_q};
            default: rd_v = 32'h0;
        endcase
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= req.rd ? rd_v : 32'h0;
        end
    end
endmodule

// [rtcc_core_checker.sv]
// port-level checker for the real-time counter core
// sees only rtcc_core ports; one core_clk domain, nrst async low
module rtcc_core_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq,
    input wire logic [7:0] periodic_tick_event,
    input wire logic ev_compare0_flag,
    input wire logic ev_cmp1,
    input wire logic ev_wrap
);
    timeunit 1ns;
    timeprecision 1ps;
    logic en_q;
    logic [3:0] presc_q;
    logic [15:0] ev_q;
    logic [3:0] dis_q;
    logic ctrl_wr;
    assign ctrl_wr = reg_wr && reg_addr == rtcc_pkg::ADDR_CTRL;
    // shadow of enable-protected fields
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            en_q <= 1'h0;
            presc_q <= 4'h0;
            ev_q <= 16'h0;
        end else if (ctrl_wr && reg_wdata[0]) begin
            en_q <= 1'h0;
            presc_q <= 4'h0;
            ev_q <= 16'h0;
        end else if (ctrl_wr) begin
            en_q <= reg_wdata[1];
            if (!en_q) presc_q <= reg_wdata[11:8];
        end else if (reg_wr && reg_addr == rtcc_pkg::ADDR_EVENT_OUTPUT_CTRL && !en_q) begin
            ev_q <= reg_wdata[15:0];
        end
    end
    // cycles spent disabled, saturating
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) dis_q <= 4'h0;
        else if (en_q) dis_q <= 4'h0;
        else if (dis_q != 4'hf) dis_q <= dis_q + 4'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    property p_soft_reset_bit_quiet;
        ctrl_wr && reg_wdata[0] ##1 !reg_wr |-> ##1 !irq && !ev_wrap && !ev_compare0_flag;
    endproperty
    a_soft_reset_bit_quiet: assert property (p_soft_reset_bit_quiet)
        else $error("irq or event after soft reset");
    property p_ienclr_irq;
        reg_wr && reg_addr == rtcc_pkg::ADDR_IEN_CLR && reg_wdata[7:0] == 8'hff
        ##1 !(reg_wr && reg_addr == rtcc_pkg::ADDR_IEN_SET) |-> ##1 !irq;
    endproperty
    a_ienclr_irq: assert property (p_ienclr_irq)
        else $error("irq stays after all sources disabled");
    property p_per_none;
        presc_q == 4'h0 && $past(presc_q) == 4'h0 && $past(presc_q, 2) == 4'h0
        |-> periodic_tick_event == 8'h0;
    endproperty
    a_per_none: assert property (p_per_none)
        else $error("periodic event with zero prescaler");
    property p_per_gate;
        (periodic_tick_event & ~ev_q[7:0] & ~$past(ev_q[7:0])) == 8'h0;
    endproperty
    a_per_gate: assert property (p_per_gate)
        else $error("periodic event while its output is off");
    property p_wrap_gate;
        !ev_q[rtcc_pkg::EV_WRAP] && !$past(ev_q[rtcc_pkg::EV_WRAP]) |-> !ev_wrap;
    endproperty
    a_wrap_gate: assert property (p_wrap_gate)
        else $error("wrap event while its output is off");
    property p_cmp_gate;
        !ev_q[rtcc_pkg::EV_COMPARE0_FLAG] && !$past(ev_q[rtcc_pkg::EV_COMPARE0_FLAG]) |-> !ev_compare0_flag;
    endproperty
    a_cmp_gate: assert property (p_cmp_gate)
        else $error("compare event while its output is off");
    property p_stopped;
        dis_q == 4'hf |-> !ev_wrap && !ev_compare0_flag && !ev_cmp1;
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("counter event while disabled");
    property p_per_space;
        presc_q != 4'h0 && en_q && periodic_tick_event[0]
        |=> !periodic_tick_event[0] [*7];
    endproperty
    a_per_space: assert property (p_per_space)
        else $error("periodic event 0 closer than eight cycles");
    property p_irq_cause;
        reg_rd && reg_addr == rtcc_pkg::ADDR_FLAGS && irq && !$past(reg_wr)
        |=> reg_rdata[7:0] != 8'h0;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq high with no flag set");
endmodule

bind rtcc_core rtcc_core_checker chk_u (.core_clk(core_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .periodic_tick_event(periodic_tick_event), .ev_compare0_flag(ev_compare0_flag),
    .ev_cmp1(ev_cmp1), .ev_wrap(ev_wrap));

// [tb_top.sv]
// self-checking bench for the real-time counter core
// drives the register port directly; prescaler source is core_clk
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, nrst, reg_wr, reg_rd, irq, ev_compare0_flag, ev_cmp1, ev_wrap;
    logic [4:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [7:0] periodic_tick_event;
    int n_mismatch = 0;
    int n_compared = 0;
    rtcc_core dut_u (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq),
        .periodic_tick_event(periodic_tick_event), .ev_compare0_flag(ev_compare0_flag),
        .ev_cmp1(ev_cmp1), .ev_wrap(ev_wrap));
    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 v = reg_rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic t_reset;
        rd(rtcc_pkg::ADDR_CTRL);
        chk(v, 32'h0);
        rd(rtcc_pkg::ADDR_TOP);
        chk(v, {16'h0, rtcc_pkg::TOP_RESET});
        wr(rtcc_pkg::ADDR_TOP, 32'hffff);
        rd(rtcc_pkg::ADDR_STATUS);
        chk(v, 32'h80);
        rd(rtcc_pkg::ADDR_STATUS);
        chk(v, 32'h0);
        rd(5'h1f);
        chk(v, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_wrap32;
        int i;
        wr(rtcc_pkg::ADDR_IEN_SET, 32'h80);
        wr(rtcc_pkg::ADDR_EVENT_OUTPUT_CTRL, 32'h8000);
        wr(rtcc_pkg::ADDR_COUNT, 32'hfffffff0);
        wr(rtcc_pkg::ADDR_COMPARE0_FLAG, 32'h1000);
        wr(rtcc_pkg::ADDR_CTRL, 32'h2);
        for (i = 0; i < 200 && irq !== 1'h1; i++) @(posedge core_clk) #1;
        if (i == 200) begin
            n_mismatch++;
            $display("[FAIL] %0t irq never rose", $time);
            close_out();
        end
        chk(ev_wrap, 1'h1);
        rd(rtcc_pkg::ADDR_FLAGS);
        chk(v & 32'h80, 32'h80);
        rd(rtcc_pkg::ADDR_COUNT);
        chk(v & 32'hffffff00, 32'h0);
        wr(rtcc_pkg::ADDR_CTRL, 32'h0);
        wr(rtcc_pkg::ADDR_FLAGS, 32'h0);
        #1 chk(irq, 1'h1);
        wr(rtcc_pkg::ADDR_FLAGS, 32'hff);
        repeat (2) @(posedge core_clk);
        #1 chk(irq, 1'h0);
        wr(rtcc_pkg::ADDR_IEN_SET, 32'h1);
        wr(rtcc_pkg::ADDR_IEN_CLR, 32'hff);
        $display("wrap32 test done");
    endtask
    task automatic t_clr32;
        int n = 0;
        wr(rtcc_pkg::ADDR_CTRL, 32'h80);
        wr(rtcc_pkg::ADDR_EVENT_OUTPUT_CTRL, 32'h100);
        wr(rtcc_pkg::ADDR_COUNT, 32'h0);
        wr(rtcc_pkg::ADDR_COMPARE0_FLAG, 32'h14);
        wr(rtcc_pkg::ADDR_CTRL, 32'h82);
        repeat (40) begin
            @(posedge core_clk);
            #1 n += ev_compare0_flag;
        end
        chk(n, 32'h1);
        wr(rtcc_pkg::ADDR_CTRL, 32'h80);
        rd(rtcc_pkg::ADDR_FLAGS);
        chk(v & 32'h81, 32'h81);
        rd(rtcc_pkg::ADDR_COUNT);
        chk(v <= 32'h14, 32'h1);
        $display("clear on match test done");
    endtask
    task automatic t_mode16;
        int n = 0;
        wr(rtcc_pkg::ADDR_CTRL, 32'h4);
        wr(rtcc_pkg::ADDR_EVENT_OUTPUT_CTRL, 32'h200);
        wr(rtcc_pkg::ADDR_TOP, 32'h7);
        wr(rtcc_pkg::ADDR_COMPARE0_FLAG, 32'h9999);
        wr(rtcc_pkg::ADDR_CMP1, 32'h5);
        wr(rtcc_pkg::ADDR_COUNT, 32'h0);
        wr(rtcc_pkg::ADDR_FLAGS, 32'hff);
        wr(rtcc_pkg::ADDR_CTRL, 32'h6);
        repeat (30) begin
            @(posedge core_clk);
            #1 n += ev_cmp1;
        end
        chk(n, 32'h3);
        wr(rtcc_pkg::ADDR_CTRL, 32'ha);
        rd(rtcc_pkg::ADDR_CTRL);
        chk(v & 32'hc, 32'h4);
        wr(rtcc_pkg::ADDR_CTRL, 32'h4);
        rd(rtcc_pkg::ADDR_FLAGS);
        chk(v & 32'h83, 32'h82);
        rd(rtcc_pkg::ADDR_COUNT);
        chk(v <= 32'h7, 32'h1);
        wr(rtcc_pkg::ADDR_DBG, 32'h1);
        wr(rtcc_pkg::ADDR_CTRL, 32'h1);
        rd(rtcc_pkg::ADDR_CTRL);
        chk(v & 32'hfff, 32'h0);
        rd(rtcc_pkg::ADDR_TOP);
        chk(v, 32'hffff);
        rd(rtcc_pkg::ADDR_DBG);
        chk(v, 32'h1);
        $display("mode16 test done");
    endtask
    task automatic t_cal;
        logic [14:0] st [3] = '{{6'h3f, 4'hc, 5'h1f}, {6'h4, 4'h2, 5'h1c},
            {6'h5, 4'h2, 5'h1c}};
        logic [14:0] ex [3] = '{{6'h0, 4'h1, 5'h1}, {6'h4, 4'h2, 5'h1d},
            {6'h5, 4'h3, 5'h1}};
        wr(rtcc_pkg::ADDR_ALARM_VALUE_0, 32'h3b);
        wr(rtcc_pkg::ADDR_AMASK0, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(rtcc_pkg::ADDR_CTRL, 32'h8);
            wr(rtcc_pkg::ADDR_FLAGS, 32'hff);
            wr(rtcc_pkg::ADDR_COUNT, {st[i], 5'h17, 6'h3b, 6'h3b});
            wr(rtcc_pkg::ADDR_CTRL, 32'ha); // fast tick for 1 Hz
            wr(rtcc_pkg::ADDR_CTRL, 32'h8);
            rd(rtcc_pkg::ADDR_COUNT);
            chk(v[31:12], {ex[i], 5'h0});
            rd(rtcc_pkg::ADDR_FLAGS);
            chk({v[7], v[0]}, {i == 0, 1'b1});
        end
        wr(rtcc_pkg::ADDR_CTRL, 32'h48);
        wr(rtcc_pkg::ADDR_COUNT, {6'h0, 4'h1, 5'h1, 5'h1b, 6'h3b, 6'h3b});
        wr(rtcc_pkg::ADDR_CTRL, 32'h4a);
        wr(rtcc_pkg::ADDR_CTRL, 32'h48);
        rd(rtcc_pkg::ADDR_COUNT);
        chk(v[31:12], {6'h0, 4'h1, 5'h2, 5'h0c});
        $display("calendar test done");
    endtask
    task automatic t_periodic;
        int n;
        n = 0;
        wr(rtcc_pkg::ADDR_CTRL, 32'h100);
        wr(rtcc_pkg::ADDR_EVENT_OUTPUT_CTRL, 32'h1);
        wr(rtcc_pkg::ADDR_CTRL, 32'h102);
        repeat (80) begin
            @(posedge core_clk);
            #1 n += periodic_tick_event[0];
        end
        chk(n >= 9 && n <= 10, 1'h1);
        wr(rtcc_pkg::ADDR_CTRL, 32'h100);
        wr(rtcc_pkg::ADDR_EVENT_OUTPUT_CTRL, 32'h0);
        $display("periodic test done");
    endtask
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        nrst = 1'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 5'h0;
        reg_wdata = 32'h0;
        repeat (5) @(posedge core_clk);
        nrst <= 1'h1;
        t_reset();
        t_wrap32();
        t_clr32();
        t_mode16();
        t_cal();
        t_periodic();
        close_out();
    end
endmodule
